/* File: hw/byte_array.sv */
// Byte-wide storage array with a guarded synchronous write port
`timescale 1ns/1ps
module byte_array
    import twowire_mem_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW = ADDR_BITS
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DATA_BITS-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DATA_BITS-1:0] rd_data
);
    logic [DATA_BITS-1:0] mem [DEPTH];

    initial begin
        if (DEPTH != (1 << AW)) begin
            $error("byte_array depth must equal two to the address width");
        end
    end

    // Commit in one cycle, read registered
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data; // R9
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: hw/pin_sync.sv */
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync
    import twowire_mem_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;

    // Level changes once second and third stages agree
    always_comb begin
        next_state = state;
        next_state.stage = {state.stage[1:0], pin};
        if (state.stage[1] == state.stage[2]) begin
            next_state.level = state.stage[2];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= {{3{RESET_LEVEL}}, RESET_LEVEL};
        end else begin
            state <= next_state;
        end
    end

    assign level = state.level;
endmodule

/* File: hw/twowire_nv_memory_slave.sv */
// Two-wire slave front end of a byte-organized nonvolatile memory
//
// Behaviour
// R1: Array holds 8192 bytes, reached only through the serial interface.
// R2: Respond only when address select bits match the three strap inputs.
// R3: Unconnected select straps read as logic zero.
// R4: Data line driven open-drain only: pull low or release.
// R5: Sample on clock rise; change outgoing bits after clock fall.
// R6: Write-protect high leaves every location unchanged.
// R7: Write-protect low allows writes to every address.
// R8: Unconnected write-protect reads as low, array writable.
// R9: Each received byte committed at bus speed, no busy period.
// R10: Next transaction may start right after a write; device accepts it.
// R11: Works at serial clock rates up to 1 MHz, also 100/400 kHz.
// R12: Address byte: type nibble high, select bits 3-1, bit 0 write-low.
// R13: Two address bytes, high first, 13 bits used, wrap 1fff to 0000.
// R14: Current-address latch advances per byte; reads start there.
// R15: Read continues while master acks; no-ack ends the read.
// R16: Protected writes still ack and advance the address latch.
`timescale 1ns/1ps
module twowire_nv_memory_slave
    import twowire_mem_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW = ADDR_BITS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [SEL_BITS-1:0] device_select_straps,
    input wire logic write_protect
);
    initial begin
        if (AW != ADDR_BITS || DEPTH != MEM_DEPTH) begin
            $error("twowire_nv_memory_slave supports only the 8192x8 array");
        end
        // Bit slot needs several filtered samples per clock phase
        if (SCL_MIN_PERIOD_CYC < 8) begin // R11
            $error("system clock too slow for 1 MHz serial clock");
        end
        // Field layout of the slave address byte
        if (SEL_MSB - SEL_LSB + 1 != SEL_BITS) begin
            $error("select field must be as wide as the strap inputs");
        end
        if (TYPE_MSB - TYPE_LSB + 1 != 4) begin
            $error("device type field must be four bits");
        end
        // Datapath and filter shapes the engine is built for
        if (DATA_BITS != 8) begin
            $error("byte engine handles eight-bit data only");
        end
        if (SYNC_STAGES != 3) begin
            $error("pin filters are built with three stages");
        end
        if (DEPTH != (1 << AW) || int'(ADDR_LAST) != DEPTH - 1) begin
            $error("array depth must fill the address space");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic scl;
    logic sda;
    logic [SEL_BITS-1:0] straps;
    logic wp;

    // Serial clock idles high
    pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin(scl_in),
        .level(scl)
    );
    // Data line idles high through the bus pull-up
    pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin(sda_in),
        .level(sda)
    );
    // Pad pull-downs make floating pins read low; sync to zero too
    genvar g;
    generate
        for (g = 0; g < SEL_BITS; g++) begin : g_strap
            pin_sync #(.RESET_LEVEL(1'b0)) u_strap_sync (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .pin(device_select_straps[g]), // R3
                .level(straps[g])
            );
        end
    endgenerate
    // Write protect, pulled down at the pad
    pin_sync #(.RESET_LEVEL(1'b0)) u_wp_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin(write_protect), // R8
        .level(wp)
    );

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        // Delayed levels for edge and condition detection
        logic scl_d;
        logic sda_d;
        // Byte sequencing
        phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        // Address latch and upper address byte
        logic [AW-1:0] cur_addr;
        logic [7:0] addr_hi;
        // Acknowledge slot and line drive
        logic in_ack;
        logic ack_drive;
        logic tx_bit;
        logic drive_low;
        // Array write request
        logic wr_en;
        logic [AW-1:0] wr_addr;
        logic [7:0] wr_data;
        // Outgoing read byte
        logic [7:0] tx_byte;
    } slave_state_t;

    // Current and next state
    slave_state_t st;
    slave_state_t next_st;
    logic [7:0] rd_data;

    // Wrapping increment of the address latch
    function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
        if (a == ADDR_LAST) begin
            return ADDR_RESET; // R13
        end
        return AW'(a + 1'b1);
    endfunction

    // Slave address byte matches type nibble and straps
    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [SEL_BITS-1:0] s);
        logic type_ok;
        logic sel_ok;
        type_ok = b[TYPE_MSB:TYPE_LSB] == DEVICE_TYPE; // R12
        sel_ok = b[SEL_MSB:SEL_LSB] == s; // R2
        return type_ok && sel_ok;
    endfunction

    // Read byte after its top bit has gone out
    function automatic logic [7:0] tx_next(input logic [7:0] b);
        return {b[6:0], 1'b0};
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] shifted;

    // Edges of the filtered serial clock
    assign scl_rise = scl && !st.scl_d;
    assign scl_fall = !scl && st.scl_d;
    // Start and stop: data moves while clock stays high
    assign start_cond = scl && st.scl_d && st.sda_d && !sda;
    assign stop_cond = scl && st.scl_d && !st.sda_d && sda;
    assign shifted = {st.shift[6:0], sda};

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine
    always_comb begin
        next_st = st;
        next_st.scl_d = scl;
        next_st.sda_d = sda;
        next_st.wr_en = 1'b0;
        if (start_cond) begin
            // Start aborts anything in progress; fresh address follows
            next_st.phase = ST_DEVADDR; // R10
            next_st.bit_cnt = 4'h0;
            next_st.in_ack = 1'b0;
            next_st.drive_low = 1'b0;
        end else if (stop_cond) begin
            next_st.phase = ST_IDLE;
            next_st.in_ack = 1'b0;
            next_st.drive_low = 1'b0;
        end else if (st.phase != ST_IDLE && scl_rise) begin
            // Sample data on rising edge
            if (st.in_ack) begin
                if (st.phase == ST_RACK && sda) begin
                    next_st.phase = ST_IDLE; // R15
                end
            end else begin
                next_st.shift = shifted; // R5
                next_st.bit_cnt = 4'(st.bit_cnt + 1'b1);
            end
        end else if (st.phase != ST_IDLE && scl_fall) begin
            // Outputs change only after falling edge
            if (st.in_ack) begin
                next_st.in_ack = 1'b0;
                next_st.bit_cnt = 4'h0;
                next_st.drive_low = 1'b0;
                if (st.phase == ST_RACK || st.phase == ST_RDATA) begin
                    next_st.phase = ST_RDATA;
                    next_st.tx_byte = tx_next(rd_data);
                    next_st.drive_low = !rd_data[7]; // R5
                    next_st.cur_addr = addr_inc(st.cur_addr); // R14
                end
            end else if (st.bit_cnt == 4'd8) begin
                next_st.in_ack = 1'b1;
                next_st.drive_low = 1'b1;
                case (st.phase)
                    ST_DEVADDR: begin
                        // Foreign address: release and wait for start
                        if (!addr_match(st.shift, straps)) begin
                            next_st.phase = ST_IDLE;
                            next_st.drive_low = 1'b0;
                            next_st.in_ack = 1'b0;
                        end else if (st.shift[DIR_BIT]) begin
                            next_st.phase = ST_RDATA; // R14
                        end else begin
                            next_st.phase = ST_ADDR_HI;
                        end
                    end
                    ST_ADDR_HI: begin
                        // Upper byte held until the lower arrives
                        next_st.addr_hi = st.shift;
                        next_st.phase = ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        // Upper three bits dropped by the cast
                        next_st.cur_addr = AW'({st.addr_hi, st.shift}); // R13
                        next_st.phase = ST_WDATA;
                    end
                    ST_WDATA: begin
                        // Protected writes still ack and advance
                        next_st.wr_en = !wp; // R6 R7 R16
                        next_st.wr_addr = st.cur_addr;
                        next_st.wr_data = st.shift;
                        next_st.cur_addr = addr_inc(st.cur_addr); // R16
                    end
                    ST_RDATA: begin
                        // Release line, wait for master ack
                        next_st.drive_low = 1'b0;
                        next_st.phase = ST_RACK;
                    end
                    default: begin
                        // Unused phase codes fall back to idle
                        next_st.phase = ST_IDLE;
                    end
                endcase
            end else if (st.phase == ST_RDATA) begin
                next_st.drive_low = !st.tx_byte[7];
                next_st.tx_byte = tx_next(st.tx_byte);
            end else begin
                next_st.drive_low = 1'b0;
            end
        end
        // First read byte loads on the ack of the address byte
        if (st.phase == ST_RDATA && st.in_ack && scl_fall) begin
            next_st.tx_byte = tx_next(rd_data);
            next_st.drive_low = !rd_data[7];
        end
    end

    // State register; line released and latch cleared in reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{scl_d: 1'b1, sda_d: 1'b1, phase: ST_IDLE,
                    cur_addr: ADDR_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage array
    byte_array #(.DEPTH(DEPTH), .AW(AW)) u_array (
        .sys_clk(sys_clk),
        .wr_en(st.wr_en), // R1 R9
        .wr_addr(st.wr_addr),
        .wr_data(st.wr_data),
        .rd_addr(st.cur_addr),
        .rd_data(rd_data)
    );

    // Open-drain data line: only pull low or release
    assign sda_out = 1'b0; // R4
    assign sda_oe = st.drive_low; // R4
endmodule

/* File: include/twowire_mem_pkg.sv */
// Constants shared by the two-wire memory slave design
package twowire_mem_pkg;
    localparam int MEM_DEPTH = 8192;
    localparam int ADDR_BITS = 13;
    localparam int DATA_BITS = 8;
    localparam int SEL_BITS = 3;
    localparam logic [12:0] ADDR_LAST = 13'h1fff;
    localparam logic [12:0] ADDR_RESET = 13'h0000;
    // Device-type nibble; value is arbitrary
    localparam logic [3:0] DEVICE_TYPE = 4'h6;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam int SYNC_STAGES = 3;
    localparam int SYS_CLK_MHZ = 100;
    localparam int SCL_MAX_KHZ = 1000;
    localparam int SCL_MIN_PERIOD_CYC = (SYS_CLK_MHZ * 1000) / SCL_MAX_KHZ;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADDR = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK = 3'b110
    } phase_t;
endpackage

/* File: test/bus_master.sv */
// Two-wire bus master model driving the clock and pulling the data line
`timescale 1ns/1ps
module bus_master (
    input wire logic sys_clk,
    input wire logic sda,
    output logic scl,
    output logic pull
);
    int q = 25; // Quarter bit, 1 MHz
    logic [8:0] seen;
    event got;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // One quarter bit at given levels
    task automatic drive(input logic c, input logic p);
        scl = c;
        pull = p;
        repeat (q) @(negedge sys_clk);
    endtask
    // Data falls while clock high
    task automatic start();
        drive(scl, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
        drive(1'b0, 1'b1);
    endtask
    // Data rises while clock high
    task automatic stop();
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
    endtask
    // Eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic a);
        logic b;
        for (int i = 8; i >= 0; i--) begin
            b = (i > 0) ? d[i-1] : a;
            drive(1'b0, !b);
            drive(1'b1, !b);
            seen[i] = sda;
            drive(1'b1, !b);
            drive(1'b0, !b);
        end
        ->got;
    endtask
endmodule

/* File: test/twowire_nv_memory_slave_properties.sv */
// Port-level checks of the two-wire memory slave
`timescale 1ns/1ps
module twowire_nv_memory_slave_checker
    import twowire_mem_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int AW = ADDR_BITS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [SEL_BITS-1:0] device_select_straps,
    input wire logic write_protect
);
    logic [3:0] nb;
    logic [7:0] sh;
    logic first, miss, rd, done;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////
    // Bit slot, address decode and read end since the last start
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nb <= 4'h0;
            sh <= 8'h00;
            first <= 1'b0;
            miss <= 1'b0;
            rd <= 1'b0;
            done <= 1'b0;
        end else if (scl_in && $fell(sda_in)) begin
            nb <= 4'h0;
            first <= 1'b1;
            miss <= 1'b0;
            done <= 1'b0;
        end else if ($rose(scl_in)) begin
            nb <= (nb == 4'h8) ? 4'h0 : nb + 4'h1;
            sh <= {sh[6:0], sda_in};
            if (nb == 4'h8) begin
                first <= 1'b0;
                done <= done | (rd & !first & sda_in);
            end
            if (first && nb == 4'h7) begin
                miss <= sh[6:0] != {DEVICE_TYPE, device_select_straps};
                rd <= sda_in;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // Ninth clock rise of a byte for a selected device
    sequence s_slot;
        $rose(scl_in) && nb == 4'h8 && !miss;
    endsequence
    property p_open_drain;
        !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda high");
    property p_edge;
        $changed(sda_oe) |-> !scl_in && !$past(scl_in, 3);
    endproperty
    a_edge: assert property (p_edge) else $error("sda moved");
    property p_foreign;
        miss |-> !sda_oe;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign ack");
    property p_quiet;
        first && nb inside {[4'h1:4'h7]} |-> !sda_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("addr clash");
    property p_dev_ack;
        s_slot ##0 first |-> sda_oe;
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("no addr ack");
    property p_data_ack;
        s_slot ##0 (!first && !rd) |-> sda_oe;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("no ack");
    property p_rd_release;
        s_slot ##0 (!first && rd) |-> !sda_oe;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("held");
    property p_done;
        done |-> !sda_oe;
    endproperty
    a_done: assert property (p_done) else $error("read went on");
endmodule
bind twowire_nv_memory_slave twowire_nv_memory_slave_checker #(
    .DEPTH(DEPTH),
    .AW(AW)
) chk (.sys_clk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe,
    .device_select_straps, .write_protect);

/* File: test/twowire_nv_memory_slave_test.sv */
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module twowire_nv_memory_slave_test;
    import twowire_mem_pkg::*;
    localparam logic [12:0] BASE = ADDR_LAST - 13'h1;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic write_protect = 1'b0;
    logic [SEL_BITS-1:0] sel;
    logic scl, pull, sda_out, sda_oe, sda_w;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h6635aeeb;
    logic [8:0] notes[$];
    logic [7:0] d[3];
    always #5 sys_clk = ~sys_clk;
    // Wired data line with pull-up
    assign sda_w = !pull && !(sda_oe && !sda_out);
    twowire_nv_memory_slave dut (.sys_clk, .nrst, .scl_in(scl),
        .sda_in(sda_w), .sda_out, .sda_oe, .device_select_straps(sel),
        .write_protect);
    bus_master bm (.sys_clk, .sda(sda_w), .scl, .pull);
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [8:0] e, input logic [8:0] s);
        tests_run++;
        if (e !== s) begin
            err_total++;
            $display("unexpected byte slot: expected %h seen %h", e, s);
        end
    endtask
    task automatic wr(input logic [7:0] v, input logic ack);
        notes.push_back({v, ack});
        bm.xfer(v, 1'b1);
    endtask
    task automatic rd(input logic [7:0] v, input logic last);
        notes.push_back({v, last});
        bm.xfer(8'hff, last);
    endtask
    task automatic head(input logic [12:0] a);
        bm.start();
        wr({DEVICE_TYPE, sel, 1'b0}, 1'b0);
        wr({3'($random(seed)), a[12:8]}, 1'b0);
        wr(a[7:0], 1'b0);
    endtask
    task automatic open_rd();
        bm.start();
        wr({DEVICE_TYPE, sel, 1'b1}, 1'b0);
    endtask
    task automatic done_test(input string n);
        $display("test %s done, mismatches so far %0d", n, err_total);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Oldest note against each finished byte slot
    always begin
        @(bm.got);
        check(notes.pop_front(), bm.seen);
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        sel = 3'($random(seed));
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (8) @(negedge sys_clk);
        foreach (d[i]) d[i] = 8'($random(seed));
        head(BASE);
        foreach (d[i]) wr(d[i], 1'b0);
        bm.stop();
        head(BASE);
        open_rd();
        foreach (d[i]) rd(d[i], 1'(i == 2));
        bm.stop();
        done_test("wrap");
        for (int j = 0; j < 17; j++) begin
            sel = 3'(j / 2);
            bm.start();
            wr({DEVICE_TYPE ^ 4'(j / 16), 3'(j / 2 + j % 2), 1'b0},
                1'(j % 2 + j / 16));
            bm.stop();
        end
        done_test("select");
        write_protect = 1'b1;
        head(BASE);
        wr(~d[0], 1'b0);
        bm.stop();
        open_rd();
        rd(d[1], 1'b1);
        bm.stop();
        write_protect = 1'b0;
        bm.q = 62;
        head(BASE);
        open_rd();
        rd(d[0], 1'b0);
        rd(d[1], 1'b1);
        bm.stop();
        done_test("protect");
        close_out();
    end
endmodule
